// *** rtl/adcrs_pkg.sv ***
`default_nettype none
package adcrs_pkg;
  // Register byte addresses on the plain register port.
  localparam logic [15:0] ADCRS_CTRL_A_ADDR = 16'h03d6;
  localparam logic [15:0] ADCRS_CTRL_B_ADDR = 16'h03d7;
  localparam logic [15:0] ADCRS_CTRL_C_ADDR = 16'h03d4;
  // Result registers sit at base plus twice the input index.
  localparam logic [15:0] ADCRS_RESULT_BASE = 16'h03c0;
  // Field positions in conv_control_a.
  localparam int ADCRS_A_CH_LSB = 0;
  localparam int ADCRS_A_MD_LSB = 3;
  localparam int ADCRS_A_TRG_BIT = 5;
  localparam int ADCRS_A_START_BIT = 6;
  localparam int ADCRS_A_CLK_DIV_SEL_LO_BIT = 7;
  // Field positions in conv_control_b.
  localparam int ADCRS_B_SPAN_LSB = 0;
  localparam int ADCRS_B_MD2_BIT = 2;
  localparam int ADCRS_B_RES_BIT = 3;
  localparam int ADCRS_B_CLK_DIV_SEL_HI_BIT = 4;
  localparam int ADCRS_B_REF_BIT = 5;
  localparam int ADCRS_B_AMP_LSB = 6;
  // Field position of the pin group select in conv_control_c.
  localparam int ADCRS_C_GRP_LSB = 1;
  // Reset values of the three control registers.
  localparam logic [7:0] ADCRS_CTRL_A_RST = 8'h00;
  localparam logic [7:0] ADCRS_CTRL_B_RST = 8'h00;
  localparam logic [7:0] ADCRS_CTRL_C_RST = 8'h00;
  // Mode field encodings handled by this sequencer.
  localparam logic [1:0] ADCRS_MODE_REPEAT = 2'h1;
  localparam logic [1:0] ADCRS_MODE_SWEEP = 2'h2;
  // Sequencer states.
  typedef enum logic [1:0] {ADCRS_IDLE, ADCRS_ARM, ADCRS_CONV} adcrs_state_t;
endpackage
`default_nettype wire

// *** rtl/adcrs_fall_detect.sv ***
`default_nettype none
module adcrs_fall_detect
  import adcrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin,
  output logic fall
);
  // Previous pin level; reset high, so a pin held low at reset shows as an edge.
  logic pin_prev;

  // Remember the pin level of the last cycle.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_prev <= 1'b1;
    end
    else
    begin
      pin_prev <= pin;
    end
  end

  // A high-to-low transition shows as a one-cycle pulse.
  assign fall = pin_prev & ~pin;
endmodule
`default_nettype wire

// *** rtl/adcrs_result_bank.sv ***
`default_nettype none
module adcrs_result_bank
  import adcrs_pkg::*;
#(
  parameter int DATA_W = 10,
  parameter int DEPTH = 8,
  parameter int IDX_W = 3
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_value
);
  // One result word per input index.
  logic [DATA_W-1:0] mem [DEPTH];

  // Each entry takes a new result only when its own index is written.
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
      begin
        mem[i] <= '0;
      end
      else if (wr_en && (wr_idx == IDX_W'(i)))
      begin
        mem[i] <= wr_data;
      end
    end
  end

  // Read port is plain combinational; the caller registers it.
  assign rd_value = mem[rd_idx];
endmodule
`default_nettype wire

// *** rtl/adcrs_top.sv ***
// How it works
// R1: Mode 01 is repeat, 10 is single sweep.
// R2: Repeat mode reconverts selected input continuously.
// R3: Repeat stops on flag clear; no interrupt.
// R4: Software trigger starts on writing start flag.
// R5: External trigger starts on falling edge after flag.
// R6: Start flag readable and writable by software.
// R7: Channel field indexes inputs zero to seven.
// R8: Input formed from channel, group, amplifier path.
// R9: Sweep span ignored in repeat mode.
// R10: Software writes secondary mode bit zero.
// R11: Sweep converts inputs once in ascending order.
// R12: Sweep blocks of two, four, six, eight.
// R13: Sweep stops at end; software trigger clears flag.
// R14: Sweep end raises the interrupt request.
// R15: Channel field ignored in single sweep mode.
// R16: Each result lands in its input's register.
// R17: Resolution bit selects 8 or 10 bits.
// R18: Software leaves control registers alone mid-conversion.
// R19: Software rewrites channel after changing mode.
// R20: Software waits 1 us after reference connect.
// R21: Span 00/01/10/11 gives 2/4/6/8 inputs.
// R22: Repeat results overwrite without overrun flag.
`default_nettype none
module adcrs_top
  import adcrs_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int NUM_CH = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic ext_trigger_pin,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  output logic conv_req,
  output logic [6:0] conv_sel,
  output logic conv_res10,
  output logic conv_irq
);
  // Software-visible control bytes.
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] ctrl_c;
  // Sequencer state and the input index under conversion.
  adcrs_state_t state;
  logic [2:0] idx;
  // Decoded control fields.
  logic [1:0] mode;
  logic start_flag;
  logic trg_ext;
  logic [2:0] channel_field;
  logic [1:0] sweep_span_field;
  logic [1:0] pin_group_sel;
  logic [1:0] amp_path_sel;
  logic mode_ok;
  // Sequencing terms shared by several processes.
  logic trig_fall;
  logic conv_ok;
  logic sweep_last;
  logic launch_first;
  logic launch;
  logic sweep_finish;
  logic [2:0] last_idx;
  logic [2:0] next_idx;
  logic [RES_W-1:0] store_data;
  logic [RES_W-1:0] bank_rd;

  // True when the address falls inside the result register window.
  function automatic logic is_result_addr(input logic [15:0] a);
    is_result_addr = (a[15:4] == ADCRS_RESULT_BASE[15:4]) && !a[0];
  endfunction

  // Input index addressed by a result register address.
  function automatic logic [2:0] result_index(input logic [15:0] a);
    result_index = a[3:1];
  endfunction

  // Field extraction from the control bytes.
  assign mode = ctrl_a[ADCRS_A_MD_LSB +: 2];
  assign start_flag = ctrl_a[ADCRS_A_START_BIT];
  assign trg_ext = ctrl_a[ADCRS_A_TRG_BIT];
  assign channel_field = ctrl_a[ADCRS_A_CH_LSB +: 3];
  assign sweep_span_field = ctrl_b[ADCRS_B_SPAN_LSB +: 2];
  assign pin_group_sel = ctrl_c[ADCRS_C_GRP_LSB +: 2];
  assign amp_path_sel = ctrl_b[ADCRS_B_AMP_LSB +: 2];

  // Only repeat and single sweep run here; other patterns leave the block idle.
  assign mode_ok = (mode == ADCRS_MODE_REPEAT) || (mode == ADCRS_MODE_SWEEP); // R1

  // The block always starts from input 0 and ends on an odd index.
  assign last_idx = {sweep_span_field, 1'b1}; // R21 R12

  // Falling edges of the external trigger pin.
  adcrs_fall_detect u_fall (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin(ext_trigger_pin),
    .fall(trig_fall)
  );

  // A conversion result that belongs to a live run.
  assign conv_ok = (state == ADCRS_CONV) && start_flag && mode_ok && conv_done;
  assign sweep_last = (mode == ADCRS_MODE_SWEEP) && (idx == last_idx);
  assign sweep_finish = conv_ok && sweep_last; // R13

  // First conversion of a run: by software write or by the pin edge.
  always_comb
  begin
    launch_first = 1'b0;
    if (start_flag && mode_ok)
    begin
      if (state == ADCRS_IDLE && !trg_ext)
      begin
        launch_first = 1'b1; // R4
      end
      else if (state == ADCRS_ARM && trig_fall)
      begin
        launch_first = 1'b1; // R5
      end
    end
  end

  // Repeat keeps going after every result; sweep goes on until the last input.
  assign launch = launch_first || (conv_ok && !sweep_last); // R2 R11

  // Index of the next conversion.
  always_comb
  begin
    if (launch_first)
    begin
      // Repeat takes the channel field and ignores the span; sweep starts at 0.
      next_idx = (mode == ADCRS_MODE_REPEAT) ? channel_field : 3'h0; // R7 R9 R15
    end
    else if (mode == ADCRS_MODE_SWEEP)
    begin
      next_idx = idx + 3'h1; // R11
    end
    else
    begin
      next_idx = idx; // R2
    end
  end

  // In 8-bit mode only the low byte of the converter word is kept.
  assign store_data = ctrl_b[ADCRS_B_RES_BIT] ? conv_data
                                               : {{(RES_W-8){1'b0}}, conv_data[7:0]}; // R17

  // Per-input result storage; a new result simply overwrites the old one.
  adcrs_result_bank #(
    .DATA_W(RES_W),
    .DEPTH(NUM_CH),
    .IDX_W(3)
  ) u_bank (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(conv_ok), // R16 R22
    .wr_idx(idx),
    .wr_data(store_data),
    .rd_idx(result_index(addr)),
    .rd_value(bank_rd)
  );

  // Control byte a; a software write beats the hardware clear of the start flag.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_a <= ADCRS_CTRL_A_RST;
    end
    else if (wr_en && (addr == ADCRS_CTRL_A_ADDR))
    begin
      ctrl_a <= wr_data; // R6
    end
    else if (sweep_finish && !trg_ext)
    begin
      // Only the software-triggered sweep drops its own start flag.
      ctrl_a[ADCRS_A_START_BIT] <= 1'b0; // R13
    end
  end

  // Control byte b; the secondary mode bit is held as written and not used here.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_b <= ADCRS_CTRL_B_RST;
    end
    else if (wr_en && (addr == ADCRS_CTRL_B_ADDR))
    begin
      ctrl_b <= wr_data;
    end
  end

  // Control byte c carries the pin group select.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_c <= ADCRS_CTRL_C_RST;
    end
    else if (wr_en && (addr == ADCRS_CTRL_C_ADDR))
    begin
      ctrl_c <= wr_data;
    end
  end

  // Sequencer state; clearing the start flag aborts at once, even mid-conversion.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ADCRS_IDLE;
    end
    else
    begin
      case (state)
        ADCRS_IDLE:
        begin
          if (start_flag && mode_ok)
          begin
            state <= trg_ext ? ADCRS_ARM : ADCRS_CONV; // R4 R5
          end
        end
        ADCRS_ARM:
        begin
          if (!start_flag || !mode_ok)
          begin
            state <= ADCRS_IDLE;
          end
          else if (trig_fall)
          begin
            state <= ADCRS_CONV; // R5
          end
        end
        ADCRS_CONV:
        begin
          if (!start_flag || !mode_ok)
          begin
            state <= ADCRS_IDLE; // R3
          end
          else if (sweep_finish)
          begin
            // With the pin trigger the flag stays set, so the block rearms for the next edge.
            state <= ADCRS_IDLE; // R13
          end
        end
        default:
        begin
          state <= ADCRS_IDLE;
        end
      endcase
    end
  end

  // Index of the input being converted.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      idx <= 3'h0;
    end
    else if (launch)
    begin
      idx <= next_idx;
    end
  end

  // Conversion request pulse and the full input selection beside it.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_req <= 1'b0;
      conv_sel <= 7'h00;
    end
    else
    begin
      conv_req <= launch;
      if (launch)
      begin
        conv_sel <= {amp_path_sel, pin_group_sel, next_idx}; // R8
      end
    end
  end

  // Interrupt request pulse; repeat mode never reaches sweep_finish.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_irq <= 1'b0;
    end
    else
    begin
      conv_irq <= sweep_finish; // R14 R3
    end
  end

  // Resolution select towards the converter.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_res10 <= 1'b0;
    end
    else
    begin
      conv_res10 <= ctrl_b[ADCRS_B_RES_BIT]; // R17
    end
  end

  // Read data stands one cycle after the strobe and is zero otherwise.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= 16'h0000;
    end
    else if (!rd_en)
    begin
      rd_data <= 16'h0000;
    end
    else if (addr == ADCRS_CTRL_A_ADDR)
    begin
      rd_data <= {8'h00, ctrl_a}; // R6
    end
    else if (addr == ADCRS_CTRL_B_ADDR)
    begin
      rd_data <= {8'h00, ctrl_b};
    end
    else if (addr == ADCRS_CTRL_C_ADDR)
    begin
      rd_data <= {8'h00, ctrl_c};
    end
    else if (is_result_addr(addr))
    begin
      rd_data <= {{(16-RES_W){1'b0}}, bank_rd}; // R16
    end
    else
    begin
      // Unmapped addresses read as zero.
      rd_data <= 16'h0000;
    end
  end

  // Patterns other than repeat and sweep never leave idle.
  property p_mode_idle;
    @(posedge clk_sys) disable iff (!rstn)
    (state == ADCRS_IDLE) && !mode_ok |=> (state == ADCRS_IDLE) && !conv_req;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("idle left in bad mode"); // R1

  // A software-triggered start requests a conversion on the next cycle.
  property p_sw_start;
    @(posedge clk_sys) disable iff (!rstn)
    (state == ADCRS_IDLE) && start_flag && mode_ok && !trg_ext |=> conv_req;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start lost"); // R4

  // Armed with no pin edge, nothing is requested.
  property p_ext_wait;
    @(posedge clk_sys) disable iff (!rstn)
    (state == ADCRS_ARM) && !trig_fall |=> !conv_req;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("start without pin edge"); // R5

  // A pin edge while armed starts a conversion.
  property p_ext_go;
    @(posedge clk_sys) disable iff (!rstn)
    (state == ADCRS_ARM) && start_flag && mode_ok && ext_trigger_pin ##1
    !ext_trigger_pin && (state == ADCRS_ARM) && start_flag && mode_ok |=> conv_req;
  endproperty
  a_ext_go: assert property (p_ext_go) else $error("pin edge missed"); // R5

  // Repeat mode requests the same channel again after each result.
  property p_repeat_again;
    @(posedge clk_sys) disable iff (!rstn)
    conv_ok && (mode == ADCRS_MODE_REPEAT) |=> conv_req && (conv_sel[2:0] == $past(idx));
  endproperty
  a_repeat_again: assert property (p_repeat_again) else $error("repeat stalled"); // R2

  // Repeat mode never raises the interrupt.
  property p_repeat_noirq;
    @(posedge clk_sys) disable iff (!rstn)
    (mode == ADCRS_MODE_REPEAT) |=> !conv_irq;
  endproperty
  a_repeat_noirq: assert property (p_repeat_noirq) else $error("irq in repeat"); // R3

  // Sweep walks upward one input at a time.
  property p_sweep_order;
    @(posedge clk_sys) disable iff (!rstn)
    conv_ok && (mode == ADCRS_MODE_SWEEP) && !sweep_last |=> (idx == $past(idx) + 3'h1);
  endproperty
  a_sweep_order: assert property (p_sweep_order) else $error("sweep out of order"); // R11

  // The last result of a sweep raises the interrupt and ends the run.
  property p_sweep_end;
    @(posedge clk_sys) disable iff (!rstn)
    sweep_finish && !trg_ext && !wr_en |=> conv_irq && !start_flag && (state == ADCRS_IDLE);
  endproperty
  a_sweep_end: assert property (p_sweep_end) else $error("sweep end wrong"); // R13

  // The last input of the span ends the sweep: the interrupt follows and no request does.
  property p_span_last;
    @(posedge clk_sys) disable iff (!rstn)
    sweep_finish |=> conv_irq && !conv_req;
  endproperty
  a_span_last: assert property (p_span_last) else $error("sweep span wrong"); // R21

  // Clearing the start flag stops a run within one cycle.
  property p_stop;
    @(posedge clk_sys) disable iff (!rstn)
    !start_flag && (state != ADCRS_IDLE) |=> (state == ADCRS_IDLE) && !conv_req;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored"); // R3
endmodule
`default_nettype wire

// *** testbench/adcrs_conv_model.sv ***
`default_nettype none
module adcrs_conv_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic conv_req,
  input wire logic [6:0] conv_sel,
  input wire logic [3:0] lat,
  input wire logic [9:0] seed,
  output logic conv_done,
  output logic [9:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles left until the result is ready; zero while idle.
  logic [3:0] left;
  // The value depends on the input index, so a result stored in the wrong place shows.
  logic [9:0] value;
  assign value = seed + {7'h00, conv_sel[2:0]};
  assign conv_done = (left == 4'h1);
  // Outside the done cycle the lines carry the inverse, so a late sample never matches.
  assign conv_data = conv_done ? value : ~value;
  // One answer per request; a slow converter is simply a larger latency.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      left <= 4'h0;
    else if (conv_req)
      left <= lat;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
endmodule
`default_nettype wire

// *** testbench/adcrs_top_bench.sv ***
`default_nettype none
module adcrs_top_bench import adcrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_trigger_pin = 1'b1;
  logic [15:0] rd_data;
  logic conv_done, conv_req, conv_res10, conv_irq;
  logic [9:0] conv_data;
  logic [6:0] conv_sel;
  // Converter latency and data offset, both drawn at random per sweep test; the repeat test redraws latency only.
  logic [3:0] lat = 4'h1;
  logic [9:0] seed = 10'h000;
  int miscompares = 0;
  int comparisons = 0;
  int req_cnt = 0;
  int irq_cnt = 0;
  logic rd_seen = 1'b0;
  // While set, requests beyond the queued notes must repeat rep_sel.
  logic rep_on = 1'b0;
  logic [6:0] rep_sel = 7'h00;
  logic [15:0] rd_q[$];
  logic [6:0] sel_q[$];
  adcrs_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_trigger_pin(ext_trigger_pin),
    .conv_done(conv_done), .conv_data(conv_data), .conv_req(conv_req),
    .conv_sel(conv_sel), .conv_res10(conv_res10), .conv_irq(conv_irq));
  adcrs_conv_model u_conv (.clk_sys(clk_sys), .rstn(rstn), .conv_req(conv_req),
    .conv_sel(conv_sel), .lat(lat), .seed(seed), .conv_done(conv_done),
    .conv_data(conv_data));
  // The clock runs at 40 MHz.
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    comparisons++;
    if (got !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // The expected value is queued; the watcher compares it in the answer cycle.
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask
  // Bounded wait for a counter; running out ends the run as a failure.
  task automatic wait_cnt(input string what, ref int cnt, input int n);
    int k;
    k = 0;
    while (cnt < n && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (cnt < n)
    begin
      miscompares++;
      $display("BAD %s expected %0d seen %0d", what, n, cnt);
      report_and_stop();
    end
  endtask
  always @(posedge clk_sys)
  begin
    rd_seen <= rd_en;
  end
  // Outputs are sampled mid-cycle, where they have settled.
  always @(negedge clk_sys)
  begin
    if (rd_seen === 1'b1 && rd_q.size() != 0)
      chk("rd_data", rd_q.pop_front(), rd_data);
    else
      chk("rd_data idle", 16'h0000, rd_data);
    if (conv_req === 1'b1)
    begin
      req_cnt++;
      if (sel_q.size() != 0)
        chk("conv_sel", {9'h000, sel_q.pop_front()}, {9'h000, conv_sel});
      else if (rep_on)
        chk("conv_sel", {9'h000, rep_sel}, {9'h000, conv_sel});
      else
        chk("conv_req", 16'h0000, 16'h0001);
    end
    if (conv_irq === 1'b1)
      irq_cnt++;
  end
  initial
  begin
    int n;
    int c;
    int k;
    void'($urandom(32'h91ec));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(ADCRS_CTRL_A_ADDR, 16'h0000);
    rd(ADCRS_CTRL_B_ADDR, 16'h0000);
    rd(ADCRS_CTRL_C_ADDR, 16'h0000);
    wr(ADCRS_RESULT_BASE, 8'hff);
    rd(ADCRS_RESULT_BASE, 16'h0000);
    wr(16'h03d5, 8'h5a);
    rd(16'h03d5, 16'h0000);
    wr(ADCRS_CTRL_B_ADDR, 8'hff);
    rd(ADCRS_CTRL_B_ADDR, 16'h00ff);
    $display("registers done");
    // Reference connected, then 40 cycles (1 us) before any start.
    wr(ADCRS_CTRL_B_ADDR, 8'h28);
    repeat (40) @(posedge clk_sys);
    // Mode pattern 11 with the start flag set must stay idle here.
    n = req_cnt;
    wr(ADCRS_CTRL_A_ADDR, 8'h58);
    repeat (10) @(posedge clk_sys);
    chk("mode 11 requests", 16'(n), 16'(req_cnt));
    wr(ADCRS_CTRL_A_ADDR, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      lat <= 4'($urandom_range(6, 1));
      seed <= 10'($urandom);
      c = $urandom_range(7, 0);
      n = 2 * s + 2;
      wr(ADCRS_CTRL_B_ADDR, 8'h28 | 8'(s));
      // The resolution output is registered one edge after the write lands.
      repeat (2) @(negedge clk_sys);
      chk("conv_res10", 16'h0001, {15'h0000, conv_res10});
      for (int i = 0; i < n; i++)
        sel_q.push_back({4'h0, 3'(i)});
      k = irq_cnt;
      wr(ADCRS_CTRL_A_ADDR, 8'h50 | 8'(c));
      wait_cnt("conv_irq", irq_cnt, k + 1);
      rd(ADCRS_CTRL_A_ADDR, {8'h00, 8'h10 | 8'(c)});
      for (int i = 0; i < n; i++)
        rd(ADCRS_RESULT_BASE + 16'(2 * i), {6'h00, seed + 10'(i)});
      chk("pending sweep", 16'h0000, 16'(sel_q.size()));
      $display("sweep span %0d done", s);
    end
    c = $urandom_range(7, 0);
    lat <= 4'($urandom_range(6, 1));
    wr(ADCRS_CTRL_C_ADDR, 8'h04);
    wr(ADCRS_CTRL_B_ADDR, 8'h63);
    repeat (2) @(negedge clk_sys);
    chk("conv_res10", 16'h0000, {15'h0000, conv_res10});
    wr(ADCRS_CTRL_A_ADDR, 8'h08);
    wr(ADCRS_CTRL_A_ADDR, 8'h08 | 8'(c));
    rep_sel = {2'h1, 2'h2, 3'(c)};
    rep_on = 1'b1;
    k = irq_cnt;
    n = req_cnt;
    wr(ADCRS_CTRL_A_ADDR, 8'h48 | 8'(c));
    rd(ADCRS_CTRL_A_ADDR, {8'h00, 8'h48 | 8'(c)});
    wait_cnt("repeat requests", req_cnt, n + 4);
    @(posedge clk_sys);
    seed <= seed + 10'h155;
    wait_cnt("repeat requests", req_cnt, n + 8);
    wr(ADCRS_CTRL_A_ADDR, 8'h08 | 8'(c));
    repeat (2) @(posedge clk_sys);
    n = req_cnt;
    repeat (30) @(posedge clk_sys);
    chk("stopped requests", 16'(n), 16'(req_cnt));
    chk("repeat irq", 16'(k), 16'(irq_cnt));
    rd(ADCRS_RESULT_BASE + 16'(2 * c), {8'h00, 8'(seed + 10'(c))});
    rep_on = 1'b0;
    $display("repeat done");
    wr(ADCRS_CTRL_C_ADDR, 8'h00);
    wr(ADCRS_CTRL_B_ADDR, 8'h28);
    sel_q.push_back(7'h00);
    sel_q.push_back(7'h01);
    n = req_cnt;
    k = irq_cnt;
    wr(ADCRS_CTRL_A_ADDR, 8'h70);
    repeat (20) @(posedge clk_sys);
    chk("armed requests", 16'(n), 16'(req_cnt));
    ext_trigger_pin <= 1'b0;
    wait_cnt("ext irq", irq_cnt, k + 1);
    @(posedge clk_sys);
    ext_trigger_pin <= 1'b1;
    // With the pin trigger the start flag stays set after the sweep.
    rd(ADCRS_CTRL_A_ADDR, 16'h0070);
    wr(ADCRS_CTRL_A_ADDR, 8'h30);
    rd(ADCRS_CTRL_A_ADDR, 16'h0030);
    $display("external trigger done");
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
`default_nettype wire
